// ===== rtl/bpa_pkg.sv
// Shared constants and state codes of the backplane bus agent
package bpa_pkg;
   // Line group widths
   localparam int ID_W  = 5;
   localparam int ARB_W = 6;
   localparam int AD_W  = 32;
   localparam int PAR_W = 4;
   localparam int SC_W  = 10;
   localparam int ERR_W = 3;

   // Positions on the system control lines
   localparam int SC_LOCK   = 1;
   localparam int SC_EOC    = 2;
   localparam int SC_RQRDY  = 3;
   localparam int SC_RPRDY  = 4;
   localparam int SC_ERR_LO = 5;

   // Released (high) levels of each line group
   localparam logic           BUS_REQUEST_LINE_IDLE = 1'h1;
   localparam logic [ARB_W-1:0] ARB_IDLE = 6'h3F;
   localparam logic [SC_W-1:0]  SC_IDLE  = 10'h3FF;
   localparam logic [AD_W-1:0]  AD_IDLE  = 32'hFFFFFFFF;
   localparam logic [PAR_W-1:0] PAR_IDLE = 4'hF;

   // Lines that carry operation definitions in the request phase
   localparam logic [SC_W-1:0]  SC_CTL_MASK = 10'h3FD;

   // Resolution phase counter: third clock, then resolved
   localparam logic [1:0] PH_ZERO = 2'h0;
   localparam logic [1:0] PH_ONE  = 2'h1;
   localparam logic [1:0] PH_LAST = 2'h2;
   localparam logic [1:0] PH_DONE = 2'h3;

   // Arbitration and ownership states
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_ARB  = 4'h2,
      ST_WAIT = 4'h4,
      ST_OWN  = 4'h8
   } bpa_arb_st_t;

   // Transfer cycle states
   typedef enum logic [2:0] {
      XF_IDLE  = 3'h1,
      XF_REQ   = 3'h2,
      XF_REPLY = 3'h4
   } bpa_xf_st_t;
endpackage

// ===== rtl/bpa_backoff.sv
`timescale 1ns/1ns
`default_nettype none
// Bit-wise back-off: from the first losing bit downward the lines are released
module bpa_backoff #(
   parameter int W = 6
) (
   input  wire logic [W-1:0] i_own_n,     // Own ID, active low
   input  wire logic [W-1:0] i_bus_n,     // Wired-AND ID seen on the bus
   output logic      [W-1:0] o_pseudo_n   // ID to drive next
);
   // Scan from the top bit, release at and below a mismatch
   always_comb begin
      logic lost;
      lost = 1'b0;
      for (int i = W - 1; i >= 0; i--) begin
         if (i_own_n[i] && !i_bus_n[i]) begin
            lost = 1'b1;
         end
         o_pseudo_n[i] = lost ? 1'b1 : i_own_n[i];
      end
   end
endmodule
`default_nettype wire

// ===== rtl/bpa_parity.sv
`timescale 1ns/1ns
`default_nettype none
// Parity of one byte lane, line low when the byte holds an odd count of ones
module bpa_parity #(
   parameter int W = 8
) (
   input  wire logic [W-1:0] i_data,   // True-level data of the lane
   output logic              o_par_n   // Parity line level
);
   // Even parity over data plus line
   assign o_par_n = ~(^i_data);
endmodule
`default_nettype wire

// ===== rtl/bpa_agent.sv
// What this block does
// - Normal request with request line high: assert request line, drive ID, priority high.
// - ID lines settle over entry clock plus two; winner valid end of third.
// - Winner takes ownership next clock, drops ID and request, starts transfers.
// - Agent not granted stays resolving, keeps request line and ID driven.
// - High-priority request joins at a new resolution phase, priority line low.
// - Low priority line makes every normal contender lose by back-off.
// - Resolved next owner waits until current owner's transfer completes.
// - ID equal to bus ID at end of resolution enters acquisition.
// - While owner transfers, pending agents arbitrate for next ownership.
// - Owner asserts end-of-cycle during the final handshake of each transfer.
// - Lock held by owner keeps ownership; nobody else takes the bus.
// - Owner releases only when transfer done, unlocked, and another resolved.
// - Last winner stops driving request line, letting a new request cycle start.
// - Resolved next owner takes over on the owner's end-of-cycle.
// - With no other requester the last owner keeps the bus.
// - Transfer only after winning, started immediately; only owner transfers.
// - 32 address/data lines plus four parity lines: address, then data.
// - Request phase carries space, width and command on control lines.
// - Reply phase splits control lines into requester and replier subsets.
// - Single transfer: one datum, one handshake, ready with end-of-cycle.
// - Read: replier drives data and ready; requester ready with end-of-cycle.
// - Write: requester drives data, end-of-cycle, ready; replier answers ready.
// - Handshake completes on the edge with both ready lines active.
// - Arbitration lines are wired AND; mismatch releases that bit and lower.
// - Normal request does not enter while a request cycle is active.
// - Sequential cycles end on end-of-cycle; this agent always issues single.
`timescale 1ns/1ns
`default_nettype none
module bpa_agent (
   input  wire logic                       i_sys_clk,                  // Bus clock
   input  wire logic                       i_srst,                     // Sync reset
   input  wire logic                       i_req_valid,                // Transfer request
   output logic                            o_req_ready,                // Request taken
   input  wire logic                       i_req_high_prio,            // Ask at high priority
   input  wire logic                       i_req_write,                // 1 write, 0 read
   input  wire logic [bpa_pkg::AD_W-1:0]   i_req_addr,                 // Address
   input  wire logic [bpa_pkg::AD_W-1:0]   i_req_wdata,                // Write data
   input  wire logic [bpa_pkg::SC_W-1:0]   i_req_ctl,                  // Space, width, command
   input  wire logic                       i_lock_hold,                // Keep bus locked
   input  wire logic [bpa_pkg::ID_W-1:0]   i_own_id,                   // Assigned ID
   output logic                            o_rsp_valid,                // Transfer done pulse
   output logic      [bpa_pkg::AD_W-1:0]   o_rsp_rdata,                // Read data
   output logic      [bpa_pkg::ERR_W-1:0]  o_rsp_err,                  // Agent error code
   output logic                            o_bus_owner,                // Agent owns bus
   input  wire logic                       i_bus_request_line_n,       // Request line level
   output logic                            o_bus_request_line,         // Request drive value
   output logic                            o_bus_request_line_oe_n,    // Request enable
   input  wire logic [bpa_pkg::ARB_W-1:0]  i_arbitration_id_lines_n,   // ID lines level
   output logic      [bpa_pkg::ARB_W-1:0]  o_arbitration_id_lines,     // ID drive value
   output logic      [bpa_pkg::ARB_W-1:0]  o_arbitration_id_lines_oe_n,// ID enables
   input  wire logic [bpa_pkg::SC_W-1:0]   i_system_control_lines_n,   // Control lines level
   output logic      [bpa_pkg::SC_W-1:0]   o_system_control_lines,     // Control drive value
   output logic      [bpa_pkg::SC_W-1:0]   o_system_control_lines_oe_n,// Control enables
   input  wire logic [bpa_pkg::AD_W-1:0]   i_addr_data_lines_n,        // AD lines level
   output logic      [bpa_pkg::AD_W-1:0]   o_addr_data_lines,          // AD drive value
   output logic      [bpa_pkg::AD_W-1:0]   o_addr_data_lines_oe_n,     // AD enables
   input  wire logic [bpa_pkg::PAR_W-1:0]  i_parity_lines_n,           // Parity level, unused
   output logic      [bpa_pkg::PAR_W-1:0]  o_parity_lines,             // Parity drive value
   output logic      [bpa_pkg::PAR_W-1:0]  o_parity_lines_oe_n         // Parity enables
);
   bpa_pkg::bpa_arb_st_t st_ff, nxt_st;
   bpa_pkg::bpa_xf_st_t  xf_ff, nxt_xf;

   logic                      pend_ff;
   logic                      pend_hp_ff;
   logic                      pend_wr_ff;
   logic [bpa_pkg::AD_W-1:0]  pend_addr_ff;
   logic [bpa_pkg::AD_W-1:0]  pend_wdata_ff;
   logic [bpa_pkg::SC_W-1:0]  pend_ctl_ff;
   logic [1:0]                ph_cnt_ff;
   logic [bpa_pkg::ARB_W-1:0] res_id_ff;
   logic                      busy_ff;
   logic                      bus_request_line_drv_n_ff;
   logic [bpa_pkg::ARB_W-1:0] arb_drv_n_ff;
   logic [bpa_pkg::SC_W-1:0]  sc_drv_n_ff;
   logic [bpa_pkg::AD_W-1:0]  ad_drv_n_ff;
   logic [bpa_pkg::PAR_W-1:0] par_drv_n_ff;
   logic                      rsp_valid_ff;
   logic [bpa_pkg::AD_W-1:0]  rsp_rdata_ff;
   logic [bpa_pkg::ERR_W-1:0] rsp_err_ff;

   logic [bpa_pkg::ARB_W-1:0] own_n;
   logic [bpa_pkg::ARB_W-1:0] pseudo_n;
   logic [bpa_pkg::AD_W-1:0]  ad_val;
   logic [bpa_pkg::PAR_W-1:0] par_n;
   logic                      bus_request_line_seen;
   logic                      lock_other;
   logic                      eoc_hs;
   logic                      ctl_active;
   logic                      new_phase;
   logic                      won;
   logic                      may_enter;
   logic                      handover_ok;
   logic                      other_resolved;
   logic                      release_bus;
   logic                      hs_mine;
   logic                      start_xf;
   logic                      accept;

   // Open-drain pins: value always low, enable carries the level
   assign o_bus_request_line     = 1'b0;
   assign o_arbitration_id_lines = '0;
   assign o_system_control_lines = '0;
   assign o_addr_data_lines      = '0;
   assign o_parity_lines         = '0;
   assign o_bus_request_line_oe_n     = bus_request_line_drv_n_ff;
   assign o_arbitration_id_lines_oe_n = arb_drv_n_ff;
   assign o_system_control_lines_oe_n = sc_drv_n_ff;
   assign o_addr_data_lines_oe_n      = ad_drv_n_ff;
   assign o_parity_lines_oe_n         = par_drv_n_ff;

   // User side outputs
   assign o_req_ready = ~pend_ff;
   assign accept      = i_req_valid & ~pend_ff;
   assign o_rsp_valid = rsp_valid_ff;
   assign o_rsp_rdata = rsp_rdata_ff;
   assign o_rsp_err   = rsp_err_ff;
   assign o_bus_owner = (st_ff == bpa_pkg::ST_OWN);

   // Own ID with priority bit on top, low for high priority
   assign own_n = {~pend_hp_ff, ~i_own_id};

   // Back-off against the wired-AND bus ID
   bpa_backoff #(
      .W (bpa_pkg::ARB_W)
   ) u_backoff (
      .i_own_n    (own_n),
      .i_bus_n    (i_arbitration_id_lines_n),
      .o_pseudo_n (pseudo_n)
   );

   // Bus observations
   assign bus_request_line_seen  = ~i_bus_request_line_n;
   assign lock_other = ~i_system_control_lines_n[bpa_pkg::SC_LOCK] & sc_drv_n_ff[bpa_pkg::SC_LOCK];
   assign eoc_hs     = ~i_system_control_lines_n[bpa_pkg::SC_EOC]
                     & ~i_system_control_lines_n[bpa_pkg::SC_RQRDY]
                     & ~i_system_control_lines_n[bpa_pkg::SC_RPRDY];
   assign ctl_active = (i_system_control_lines_n & bpa_pkg::SC_CTL_MASK) != bpa_pkg::SC_CTL_MASK;

   // Phase events: settle, resolve, withdraw of the winner
   assign new_phase      = bus_request_line_seen && (ph_cnt_ff == bpa_pkg::PH_DONE)
                           && (i_arbitration_id_lines_n != res_id_ff);
   assign won            = (ph_cnt_ff == bpa_pkg::PH_LAST)
                           && (i_arbitration_id_lines_n == own_n);
   assign may_enter      = pend_ff && (pend_hp_ff ? (!bus_request_line_seen || new_phase)
                                                  : !bus_request_line_seen);
   assign handover_ok    = !lock_other && (!busy_ff || eoc_hs);
   assign other_resolved = bus_request_line_seen && (ph_cnt_ff == bpa_pkg::PH_DONE);
   assign release_bus    = (xf_ff == bpa_pkg::XF_IDLE) && !i_lock_hold
                           && other_resolved;
   assign hs_mine        = (xf_ff == bpa_pkg::XF_REPLY)
                           && !sc_drv_n_ff[bpa_pkg::SC_RQRDY]
                           && !i_system_control_lines_n[bpa_pkg::SC_RPRDY];

   // Resolution phase counter shared view of the bus
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         ph_cnt_ff <= bpa_pkg::PH_ZERO;
      end else if (!bus_request_line_seen) begin
         ph_cnt_ff <= bpa_pkg::PH_ZERO;
      end else if (new_phase) begin
         ph_cnt_ff <= bpa_pkg::PH_ONE;
      end else if (ph_cnt_ff != bpa_pkg::PH_DONE) begin
         ph_cnt_ff <= 2'(ph_cnt_ff + bpa_pkg::PH_ONE);
      end
   end

   // Resolved ID, held to spot the winner withdrawing
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         res_id_ff <= bpa_pkg::ARB_IDLE;
      end else if (ph_cnt_ff == bpa_pkg::PH_LAST) begin
         res_id_ff <= i_arbitration_id_lines_n;
      end
   end

   // Transfer activity of any owner, ended by its end-of-cycle handshake
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         busy_ff <= 1'b0;
      end else begin
         busy_ff <= eoc_hs ? 1'b0 : (busy_ff | ctl_active);
      end
   end

   // Arbitration and ownership next state
   always_comb begin
      nxt_st = st_ff;
      unique case (st_ff)
         bpa_pkg::ST_IDLE: begin
            if (may_enter) begin
               nxt_st = bpa_pkg::ST_ARB;
            end
         end
         bpa_pkg::ST_ARB: begin
            if (won) begin
               nxt_st = handover_ok ? bpa_pkg::ST_OWN : bpa_pkg::ST_WAIT;
            end
         end
         bpa_pkg::ST_WAIT: begin
            if (handover_ok) begin
               nxt_st = bpa_pkg::ST_OWN;
            end
         end
         bpa_pkg::ST_OWN: begin
            if (release_bus) begin
               nxt_st = bpa_pkg::ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         st_ff <= bpa_pkg::ST_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Transfer cycle next state, started on gaining or holding ownership
   assign start_xf = pend_ff && (nxt_st == bpa_pkg::ST_OWN);
   always_comb begin
      nxt_xf = xf_ff;
      unique case (xf_ff)
         bpa_pkg::XF_IDLE: begin
            if (start_xf) begin
               nxt_xf = bpa_pkg::XF_REQ;
            end
         end
         bpa_pkg::XF_REQ: begin
            nxt_xf = bpa_pkg::XF_REPLY;
         end
         bpa_pkg::XF_REPLY: begin
            if (hs_mine) begin
               nxt_xf = bpa_pkg::XF_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         xf_ff <= bpa_pkg::XF_IDLE;
      end else begin
         xf_ff <= nxt_xf;
      end
   end

   // Pending request: taken when free, freed by its own handshake
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         pend_ff <= 1'b0;
      end else if (accept) begin
         pend_ff <= 1'b1;
      end else if (hs_mine) begin
         pend_ff <= 1'b0;
      end
   end

   // Request details held through the whole transfer cycle
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         pend_hp_ff    <= 1'b0;
         pend_wr_ff    <= 1'b0;
         pend_addr_ff  <= '0;
         pend_wdata_ff <= '0;
         pend_ctl_ff   <= '0;
      end else if (accept) begin
         pend_hp_ff    <= i_req_high_prio;
         pend_wr_ff    <= i_req_write;
         pend_addr_ff  <= i_req_addr;
         pend_wdata_ff <= i_req_wdata;
         pend_ctl_ff   <= i_req_ctl;
      end
   end

   // Request line and ID driven only while contending
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         bus_request_line_drv_n_ff <= bpa_pkg::BUS_REQUEST_LINE_IDLE;
         arb_drv_n_ff  <= bpa_pkg::ARB_IDLE;
      end else if (nxt_st == bpa_pkg::ST_ARB || nxt_st == bpa_pkg::ST_WAIT) begin
         bus_request_line_drv_n_ff <= 1'b0;
         arb_drv_n_ff  <= pseudo_n;
      end else begin
         bus_request_line_drv_n_ff <= bpa_pkg::BUS_REQUEST_LINE_IDLE;
         arb_drv_n_ff  <= bpa_pkg::ARB_IDLE;
      end
   end

   // Address in the request phase, write data in the reply phase
   assign ad_val = (nxt_xf == bpa_pkg::XF_REQ) ? pend_addr_ff : pend_wdata_ff;

   for (genvar g = 0; g < bpa_pkg::PAR_W; g++) begin : g_par
      bpa_parity #(
         .W (8)
      ) u_par (
         .i_data  (ad_val[8*g +: 8]),
         .o_par_n (par_n[g])
      );
   end

   // Address/data and parity lines
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         ad_drv_n_ff  <= bpa_pkg::AD_IDLE;
         par_drv_n_ff <= bpa_pkg::PAR_IDLE;
      end else if (nxt_xf == bpa_pkg::XF_REQ
                   || (nxt_xf == bpa_pkg::XF_REPLY && pend_wr_ff)) begin
         ad_drv_n_ff  <= ~ad_val;
         par_drv_n_ff <= par_n;
      end else begin
         ad_drv_n_ff  <= bpa_pkg::AD_IDLE;
         par_drv_n_ff <= bpa_pkg::PAR_IDLE;
      end
   end

   // Control lines: definitions, then requester ready with end-of-cycle, lock
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         sc_drv_n_ff <= bpa_pkg::SC_IDLE;
      end else begin
         sc_drv_n_ff <= bpa_pkg::SC_IDLE;
         if (nxt_xf == bpa_pkg::XF_REQ) begin
            sc_drv_n_ff <= ~pend_ctl_ff | ~bpa_pkg::SC_CTL_MASK;
         end else if (nxt_xf == bpa_pkg::XF_REPLY && xf_ff == bpa_pkg::XF_REPLY) begin
            sc_drv_n_ff[bpa_pkg::SC_EOC]   <= 1'b0;
            sc_drv_n_ff[bpa_pkg::SC_RQRDY] <= 1'b0;
         end
         if (nxt_st == bpa_pkg::ST_OWN && i_lock_hold) begin
            sc_drv_n_ff[bpa_pkg::SC_LOCK] <= 1'b0;
         end
      end
   end

   // Answer captured on the completing handshake
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         rsp_valid_ff <= 1'b0;
         rsp_rdata_ff <= '0;
         rsp_err_ff   <= '0;
      end else begin
         rsp_valid_ff <= hs_mine;
         if (hs_mine) begin
            rsp_rdata_ff <= pend_wr_ff ? '0 : ~i_addr_data_lines_n;
            rsp_err_ff   <= ~i_system_control_lines_n[bpa_pkg::SC_ERR_LO +: bpa_pkg::ERR_W];
         end
      end
   end
endmodule
`default_nettype wire

// ===== tb/bpa_agent_sva.sv
`timescale 1ns/1ns
`default_nettype none
// Pin-level checks of the bus agent
module bpa_agent_sva (
   input wire logic       i_sys_clk,                   // Clock
   input wire logic       i_srst,                      // Reset
   input wire logic       i_lock_hold,                 // Lock ask
   input wire logic       o_req_ready,                 // Idle
   input wire logic       o_rsp_valid,                 // Done
   input wire logic       o_bus_owner,                 // Owner
   input wire logic       i_bus_request_line_n,        // Request line
   input wire logic       o_bus_request_line_oe_n,     // Request enable
   input wire logic [5:0] i_arbitration_id_lines_n,    // ID lines
   input wire logic [5:0] o_arbitration_id_lines_oe_n, // ID enables
   input wire logic [9:0] i_system_control_lines_n,    // Control lines
   input wire logic [9:0] o_system_control_lines_oe_n  // Control enables
);
   // Handshake with own end-of-cycle
   wire logic hs = !o_system_control_lines_oe_n[2] && !i_system_control_lines_n[3] && !i_system_control_lines_n[4];
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);
   // Normal entry, then three quiet settle clocks
   sequence s_enter;
      $fell(o_bus_request_line_oe_n) && o_arbitration_id_lines_oe_n[5];
   endsequence
   sequence s_quiet3;
      ((i_arbitration_id_lines_n == o_arbitration_id_lines_oe_n) && (&i_system_control_lines_n))[*3];
   endsequence
   a_rst_release: assert property ($fell(i_srst) |-> o_bus_request_line_oe_n && (&o_arbitration_id_lines_oe_n)
      && (&o_system_control_lines_oe_n) && o_req_ready && !o_bus_owner) else $error("lines held after reset");
   a_normal_entry: assert property (s_enter |-> $past(i_bus_request_line_n))
      else $error("normal entry while request cycle active");
   a_settle_wait: assert property (s_enter |-> (!o_bus_owner)[*3])
      else $error("ownership before settling");
   a_win_take: assert property (s_enter ##0 s_quiet3 |=> o_bus_owner)
      else $error("winner did not take ownership");
   a_owner_quiet: assert property (o_bus_owner |-> o_bus_request_line_oe_n && (&o_arbitration_id_lines_oe_n))
      else $error("owner still drives request or ID");
   a_eoc_pair: assert property (o_system_control_lines_oe_n[2] == o_system_control_lines_oe_n[3])
      else $error("end-of-cycle apart from requester ready");
   a_xfer_owner: assert property (|(~o_system_control_lines_oe_n & 10'h3FD) |-> o_bus_owner)
      else $error("transfer without ownership");
   a_hs_done: assert property (hs |=> o_rsp_valid && o_system_control_lines_oe_n[3])
      else $error("handshake not completed");
   a_rsp_cause: assert property (o_rsp_valid |-> $past(hs))
      else $error("done without handshake");
   a_lock_keep: assert property (o_bus_owner && i_lock_hold |=> o_bus_owner)
      else $error("ownership lost while locked");
endmodule
bind bpa_agent bpa_agent_sva u_sva (.i_sys_clk, .i_srst, .i_lock_hold, .o_req_ready, .o_rsp_valid, .o_bus_owner,
   .i_bus_request_line_n, .o_bus_request_line_oe_n, .i_arbitration_id_lines_n, .o_arbitration_id_lines_oe_n,
   .i_system_control_lines_n, .o_system_control_lines_oe_n);
`default_nettype wire

// ===== tb/bpa_replier.sv
`timescale 1ns/1ns
`default_nettype none
// Replying agent on the far side
module bpa_replier (
   input wire logic        i_sys_clk, // Clock
   input wire logic        i_srst,    // Reset
   input wire logic        i_read,    // Read cycle
   input wire logic [3:0]  i_dly,     // Wait clocks
   input wire logic [2:0]  i_err,     // Error code
   input wire logic [31:0] i_rdata,   // Read datum
   input wire logic [9:0]  i_sc_n,    // Control lines
   input wire logic [31:0] i_ad_n,    // AD lines
   output logic     [9:0]  o_sc_oe_n, // Control enables
   output logic     [31:0] o_ad_oe_n, // AD enables
   output logic     [31:0] o_wdata    // Taken write datum
);
   logic      [3:0] cnt_ff;
   logic            ack_ff;
   wire logic       hs = !i_sc_n[3] && !i_sc_n[4];
   // Answer requester ready with end-of-cycle after the set wait
   always_ff @(posedge i_sys_clk) begin
      if (i_srst || hs) begin
         cnt_ff <= 4'h0;
         ack_ff <= 1'b0;
      end else if (!i_sc_n[3] && !i_sc_n[2] && !ack_ff) begin
         ack_ff <= (cnt_ff == i_dly);
         cnt_ff <= cnt_ff + 4'h1;
      end
   end
   // Take written datum at the handshake
   always_ff @(posedge i_sys_clk) begin
      if (hs) begin
         o_wdata <= ~i_ad_n;
      end
   end
   // Ready and error code, data on reads
   assign o_sc_oe_n = ack_ff ? ~{2'h0, i_err, 5'h10} : 10'h3FF;
   assign o_ad_oe_n = (ack_ff && i_read) ? ~i_rdata : 32'hFFFFFFFF;
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic        i_sys_clk = 1'b0, i_srst = 1'b1, i_req_valid = 1'b0, i_req_write = 1'b0, i_lock_hold = 1'b0;
   logic        i_req_high_prio = 1'b0;
   logic        rp_read = 1'b0, rv_bus_request_line_oe_n = 1'b1, o_req_ready, o_rsp_valid, o_bus_owner, dut_bus_request_line_oe_n;
   logic [31:0] i_req_addr = 32'h0, i_req_wdata = 32'h0, rp_rdata = 32'h0, rp_wdata, o_rsp_rdata;
   logic [31:0] dut_ad_oe_n, rp_ad_oe_n;
   logic [9:0]  i_req_ctl = 10'h0, dut_sc_oe_n, rp_sc_oe_n;
   logic [5:0]  rv_arb_oe_n = 6'h3F, dut_arb_oe_n;
   logic [3:0]  rp_dly = 4'h0, par_n;
   logic [2:0]  rp_err = 3'h0, o_rsp_err;
   int          checks = 0, mismatches = 0, cycles = 0, n;
   // Wired-AND bus levels
   wire logic        bus_request_line_n = dut_bus_request_line_oe_n & rv_bus_request_line_oe_n;
   wire logic [5:0]  arb_n  = dut_arb_oe_n & rv_arb_oe_n;
   wire logic [9:0]  sc_n   = dut_sc_oe_n & rp_sc_oe_n;
   wire logic [31:0] ad_n   = dut_ad_oe_n & rp_ad_oe_n;
   // Drive values of the open-drain pins
   wire logic [52:0] pin_v;
   bpa_agent DUT (.i_sys_clk, .i_srst, .i_req_valid, .o_req_ready, .i_req_high_prio, .i_req_write,
      .i_req_addr, .i_req_wdata, .i_req_ctl, .i_lock_hold, .i_own_id(5'h0A), .o_rsp_valid, .o_rsp_rdata,
      .o_rsp_err, .o_bus_owner, .i_bus_request_line_n(bus_request_line_n), .o_bus_request_line(pin_v[0]),
      .o_bus_request_line_oe_n(dut_bus_request_line_oe_n), .i_arbitration_id_lines_n(arb_n),
      .o_arbitration_id_lines(pin_v[6:1]), .o_arbitration_id_lines_oe_n(dut_arb_oe_n),
      .i_system_control_lines_n(sc_n), .o_system_control_lines(pin_v[16:7]),
      .o_system_control_lines_oe_n(dut_sc_oe_n), .i_addr_data_lines_n(ad_n), .o_addr_data_lines(pin_v[48:17]),
      .o_addr_data_lines_oe_n(dut_ad_oe_n), .i_parity_lines_n(par_n), .o_parity_lines(pin_v[52:49]),
      .o_parity_lines_oe_n(par_n));
   bpa_replier u_rep (.i_sys_clk, .i_srst, .i_read(rp_read), .i_dly(rp_dly), .i_err(rp_err), .i_rdata(rp_rdata),
      .i_sc_n(sc_n), .i_ad_n(ad_n), .o_sc_oe_n(rp_sc_oe_n), .o_ad_oe_n(rp_ad_oe_n), .o_wdata(rp_wdata));
   // Clock and hang limit
   always #25 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         close_out();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // One single transfer, request phase and answer judged
   task automatic xfer(input logic wr, input logic [31:0] a, d, input logic [9:0] c, output int cnt);
      int k;
      i_req_write = wr;
      i_req_addr  = a;
      i_req_wdata = d;
      i_req_ctl   = c;
      rp_read     = !wr;
      rp_rdata    = d;
      i_req_valid = 1'b1;
      @(negedge i_sys_clk);
      i_req_valid = 1'b0;
      cnt = 1;
      // Count clocks until the owner shows its request phase
      while ((o_bus_owner & ~dut_sc_oe_n[0]) !== 1'b1 && cnt < 60) begin
         @(negedge i_sys_clk);
         cnt++;
      end
      chk(ad_n, ~a);
      chk(sc_n & 10'h3FD, ~c & 10'h3FD);
      for (k = 0; k < 4; k++) chk(par_n[k], ~^a[8*k+:8]);
      k = 0;
      while (o_rsp_valid !== 1'b1 && k < 60) begin
         @(negedge i_sys_clk);
         k++;
      end
      chk(o_rsp_valid, 1'b1);
      chk(wr ? rp_wdata : o_rsp_rdata, d);
      chk(o_rsp_err, rp_err);
   endtask
   task automatic sc_reset;
      chk({o_bus_owner, o_req_ready, dut_bus_request_line_oe_n, dut_arb_oe_n}, {3'h3, 6'h3F});
      chk(&{dut_sc_oe_n, dut_ad_oe_n, par_n}, 1'b1);
      chk(|pin_v, 1'b0);
      $display("test reset done");
   endtask
   task automatic sc_write;
      xfer(1'b1, 32'h8001A5C3, 32'hC0FFEE01, 10'h3E1, n);
      chk(n, 5);
      $display("test first write done");
   endtask
   task automatic sc_read;
      rp_dly = 4'h5;
      rp_err = 3'h5;
      xfer(1'b0, 32'h00000FF0, 32'h5A5AA5A7, 10'h101, n);
      chk(n, 2);
      rp_err = 3'h0;
      $display("test slow read done");
   endtask
   task automatic sc_lock;
      i_lock_hold = 1'b1;
      @(negedge i_sys_clk);
      rv_bus_request_line_oe_n = 1'b0;
      rv_arb_oe_n  = 6'h20;
      repeat (10) begin
         @(negedge i_sys_clk);
         chk({o_bus_owner, dut_sc_oe_n[1]}, 2'h2);
      end
      xfer(1'b1, 32'h7FFFFFFE, 32'h00000001, 10'h3E1, n);
      chk(n, 2);
      i_lock_hold = 1'b0;
      n = 0;
      while (o_bus_owner !== 1'b0 && n < 10) begin
         @(negedge i_sys_clk);
         n++;
      end
      chk(o_bus_owner, 1'b0);
      $display("test lock done");
   endtask
   // Rival owns, request cycle still active, then released
   task automatic sc_handover;
      rv_arb_oe_n = 6'h3F;
      fork
         xfer(1'b1, 32'h00000010, 32'hFFFFFFFF, 10'h3E1, n);
         begin
            repeat (6) begin
               @(negedge i_sys_clk);
               chk(dut_bus_request_line_oe_n, 1'b1);
            end
            rv_bus_request_line_oe_n = 1'b1;
         end
      join
      $display("test handover done");
   endtask
   // Request cycle active: high priority joins only when a new phase starts
   task automatic sc_high_prio;
      i_req_high_prio = 1'b1;
      rv_bus_request_line_oe_n    = 1'b0;
      rv_arb_oe_n     = 6'h3E;
      repeat (6) @(negedge i_sys_clk);
      fork
         xfer(1'b0, 32'h00000020, 32'h13579BDF, 10'h3E1, n);
         begin
            repeat (3) begin
               @(negedge i_sys_clk);
               chk(dut_bus_request_line_oe_n, 1'b1);
            end
            rv_arb_oe_n = 6'h3F;
            @(negedge i_sys_clk);
            chk(dut_arb_oe_n, 6'h15);
         end
      join
      rv_bus_request_line_oe_n    = 1'b1;
      i_req_high_prio = 1'b0;
      $display("test high priority done");
   endtask
   // Main sequence
   initial begin
      repeat (4) @(negedge i_sys_clk);
      i_srst = 1'b0;
      sc_reset();
      sc_write();
      sc_read();
      sc_lock();
      sc_handover();
      sc_high_prio();
      close_out();
   end
endmodule
`default_nettype wire
